// *** core/nand_dev.sv ***
// Notes on behaviour
// - correction enable gates ecc on load and read
// - ecc computed from main area into spare
// - read results update two correction status bits
// - uncorrectable page in stream reports 10 or 11
// - a9h plus 8 dummies returns last failing page
// - d8h, dummy byte, page address erases block
// - erase needs write latch set
// - erase only if cs rises after bit 32
// - busy held for erase time then cleared
// - write latch cleared when erase ends
// - protected block erase is skipped
// - loading only fills buffer, execute is separate
// - loads need write latch set
// - load opcode, 16-bit column, 12 bits used
// - host holds cs low through whole load
// - bytes past buffer end are dropped
// - 02h fills rest with ffh, 84h keeps
// - ecc on overwrites spare parity byte
// - quad loads carry data on four lines
// - 32h fills with ffh, 34h keeps
// - protect pin enable rejects quad commands
// - 06h sets write latch
// - continuous mode accumulates status over pages
// - status reads accepted even while busy
`timescale 1ns/10ps
`default_nettype none
module nand_dev #(
	parameter int ERASE_CYCLES = nand_pkg::ERASE_CYCLES
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic ce_i, // clock enable
	nand_link_if.device link, // serial link
	input wire logic correction_enable_i, // internal ecc on
	input wire logic buffer_read_select_i, // 0: continuous read
	input wire logic protect_pin_enable_i, // quad commands off
	input wire logic protect_top_bottom_i, // protect from bottom
	input wire logic protect_level_bit2_i, // protect level msb
	input wire logic protect_level_bit1_i, // protect level
	input wire logic protect_level_bit0_i, // protect level lsb
	input wire logic rd_start_i, // array read begins
	input wire logic rd_page_done_i, // one page checked
	input wire logic [1:0] rd_result_i, // page check outcome
	input wire logic [15:0] rd_page_i, // page just checked
	input wire logic [11:0] buf_idx_i, // buffer read index
	output logic [7:0] buf_data_o, // buffer byte
	output logic busy_o, // erase running
	output logic write_latch_flag_o, // write latch
	output logic erase_start_o, // erase begins pulse
	output logic [9:0] erase_block_o, // block being erased
	output logic erase_done_o, // erase ends pulse
	output logic [1:0] correction_status_o, // ecc status
	output logic [15:0] fail_page_o // last failing page
);
	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	function automatic logic is_quad(input logic [7:0] c);
		is_quad = (c == nand_pkg::OP_QLOAD) || (c == nand_pkg::OP_QRLOAD);
	endfunction : is_quad
	function automatic logic is_load(input logic [7:0] c);
		is_load = is_quad(c) || (c == nand_pkg::OP_LOAD) || (c == nand_pkg::OP_RLOAD);
	endfunction : is_load
	function automatic logic is_fill(input logic [7:0] c);
		is_fill = (c == nand_pkg::OP_LOAD) || (c == nand_pkg::OP_QLOAD);
	endfunction : is_fill
	function automatic logic is_rdsr(input logic [7:0] c);
		is_rdsr = (c == nand_pkg::OP_RDSR_A) || (c == nand_pkg::OP_RDSR_B);
	endfunction : is_rdsr
	function automatic logic cmd_ok(input logic [7:0] c, input logic bsy, input logic wl,
		input logic wp);
		logic needs_wel;
		needs_wel = is_load(c) || (c == nand_pkg::OP_ERASE);
		cmd_ok = is_rdsr(c) || (c == nand_pkg::OP_FAILPG) ||
			(!bsy && !(is_quad(c) && wp) && (!needs_wel || wl));
	endfunction : cmd_ok
	function automatic logic blk_locked(input logic [9:0] b, input logic tb,
		input logic [2:0] lvl);
		logic [10:0] span;
		span = (lvl == 3'h0) ? 11'h0 : (nand_pkg::BLOCKS >> (nand_pkg::LVL_ALL - lvl));
		blk_locked = tb ? ({1'b0, b} < span) : ({1'b0, b} >= nand_pkg::BLOCKS - span);
	endfunction : blk_locked

	typedef enum logic {ENG_READY, ENG_ERASE} eng_t;

	logic [5:0] s1;
	logic [5:0] s2;
	logic sclk_q;
	logic cs_q;
	logic [5:0] cnt;
	logic [7:0] sh;
	logic [7:0] op;
	logic [15:0] addr;
	logic [11:0] col;
	logic [2:0] bitc;
	logic outen;
	logic [15:0] sout;
	logic dout;
	logic write_latch_flag;
	logic [1:0] ecc_st;
	logic [15:0] fail_page;
	eng_t eng;
	logic [31:0] timer;
	logic [7:0] buffer [nand_pkg::PAGE_BYTES];
	logic [7:0] main_xor;

	// ---------------------------------------------------------------
	// pin sampling and frame decode
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1 <= nand_pkg::PIN_IDLE;
			s2 <= nand_pkg::PIN_IDLE;
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
		end
		else if (ce_i)
		begin
			s1 <= {link.cs_n, link.sclk, link.io};
			s2 <= s1;
			sclk_q <= s2[4];
			cs_q <= s2[5];
		end
	end

	wire logic busy = (eng == ENG_ERASE);
	wire logic cs_high = s2[5];
	wire logic cs_rise = s2[5] & ~cs_q;
	wire logic sclk_rise = ~cs_high & s2[4] & ~sclk_q;
	wire logic sclk_fall = ~cs_high & ~s2[4] & sclk_q;
	wire logic [7:0] sh_next = {sh[6:0], s2[0]};
	wire logic [7:0] qsh_next = {sh[3:0], s2[3:0]};
	wire logic data_ph = is_load(op) && (cnt >= nand_pkg::CNT_COL);
	wire logic op_take = sclk_rise && (cnt == nand_pkg::CNT_OP - 6'h1);
	wire logic [7:0] op_next = cmd_ok(sh_next, busy, write_latch_flag, protect_pin_enable_i) ?
		sh_next : nand_pkg::OP_NONE;
	wire logic byte_done = sclk_rise && data_ph && (is_quad(op) ? bitc[0] : &bitc);
	wire logic [7:0] byte_val = is_quad(op) ? qsh_next : sh_next;
	wire logic wr_buf = byte_done && (col < nand_pkg::PAGE_END);
	wire logic fill_all = op_take && is_fill(op_next);
	wire logic load_end = cs_rise && is_load(op) && correction_enable_i;
	wire logic [2:0] lvl = {protect_level_bit2_i, protect_level_bit1_i, protect_level_bit0_i};
	wire logic [9:0] blk = addr[15:nand_pkg::BLK_LSB];
	wire logic erase_go = cs_rise && (op == nand_pkg::OP_ERASE) &&
		(cnt == nand_pkg::CNT_ERASE) && write_latch_flag && !busy &&
		!blk_locked(blk, protect_top_bottom_i, lvl);
	wire logic out_load = sclk_rise && (cnt == nand_pkg::CNT_DUMMY - 6'h1) &&
		(is_rdsr(op) || op == nand_pkg::OP_FAILPG);
	wire logic [7:0] status_byte = (8'(busy) << nand_pkg::ST_BUSY) |
		(8'(write_latch_flag) << nand_pkg::ST_WEL) | (8'(ecc_st) << nand_pkg::ST_ECC);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt <= '0;
			sh <= '0;
			op <= nand_pkg::OP_NONE;
			addr <= '0;
			col <= '0;
			bitc <= '0;
		end
		else if (ce_i && cs_high)
		begin
			cnt <= '0;
			bitc <= '0;
			if (!cs_rise)
				op <= nand_pkg::OP_NONE;
		end
		else if (ce_i && sclk_rise)
		begin
			cnt <= (cnt == nand_pkg::CNT_MAX) ? cnt : cnt + 6'h1;
			sh <= data_ph && is_quad(op) ? qsh_next : sh_next;
			if (op_take)
				op <= op_next;
			if (cnt >= nand_pkg::CNT_OP && cnt < nand_pkg::CNT_ERASE)
				addr <= {addr[14:0], s2[0]};
			if (data_ph)
				bitc <= bitc + 3'h1;
			if (cnt == nand_pkg::CNT_COL - 6'h1)
				col <= {addr[10:0], s2[0]};
			else if (wr_buf)
				col <= col + 12'h1;
		end
	end

	// ---------------------------------------------------------------
	// serial output: status byte repeats, page address repeats
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i || (ce_i && cs_high))
		begin
			outen <= 1'b0;
			sout <= '0;
			dout <= 1'b0;
		end
		else if (ce_i && out_load)
		begin
			outen <= 1'b1;
			sout <= is_rdsr(op) ? {status_byte, status_byte} : fail_page;
		end
		else if (ce_i && sclk_fall && outen)
		begin
			dout <= sout[15];
			sout <= {sout[14:0], sout[15]};
		end
	end

	assign link.d_do = dout;
	assign link.d_do_oe = outen;

	// ---------------------------------------------------------------
	// page buffer; the array program step lives outside this block
	// ---------------------------------------------------------------
	always_comb
	begin
		main_xor = '0;
		for (int i = 0; i < nand_pkg::MAIN_BYTES; i++)
			main_xor = main_xor ^ buffer[i];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < nand_pkg::PAGE_BYTES; i++)
				buffer[i] <= nand_pkg::FILL_BYTE;
			buf_data_o <= '0;
		end
		else if (ce_i)
		begin
			if (fill_all)
				for (int i = 0; i < nand_pkg::PAGE_BYTES; i++)
					buffer[i] <= nand_pkg::FILL_BYTE;
			else if (wr_buf)
				buffer[col] <= byte_val;
			else if (load_end)
				buffer[nand_pkg::PARITY_IDX] <= main_xor;
			buf_data_o <= (buf_idx_i < nand_pkg::PAGE_END) ? buffer[buf_idx_i] :
				nand_pkg::FILL_BYTE;
		end
	end

	// ---------------------------------------------------------------
	// erase engine and write latch
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			eng <= ENG_READY;
			timer <= '0;
			erase_start_o <= 1'b0;
			erase_done_o <= 1'b0;
			erase_block_o <= '0;
		end
		else if (ce_i)
		begin
			erase_start_o <= 1'b0;
			erase_done_o <= 1'b0;
			case (eng)
				ENG_READY:
					if (erase_go)
					begin
						eng <= ENG_ERASE;
						timer <= 32'(ERASE_CYCLES - 1);
						erase_start_o <= 1'b1;
						erase_block_o <= blk;
					end
				ENG_ERASE:
					if (timer == '0)
					begin
						eng <= ENG_READY;
						erase_done_o <= 1'b1;
					end
					else
						timer <= timer - 32'h1;
				default:
					eng <= ENG_READY;
			endcase
		end
	end

	wire logic frame8 = cs_rise && (cnt == nand_pkg::CNT_OP);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			write_latch_flag <= 1'b0;
		else if (ce_i && busy && timer == '0)
			write_latch_flag <= 1'b0;
		else if (ce_i && frame8 && op == nand_pkg::OP_WREN)
			write_latch_flag <= 1'b1;
		else if (ce_i && frame8 && op == nand_pkg::OP_WRDI)
			write_latch_flag <= 1'b0;
	end

	// ---------------------------------------------------------------
	// correction status; in continuous mode a failure stays sticky
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ecc_st <= nand_pkg::ECC_OK;
			fail_page <= '0;
		end
		else if (ce_i && rd_start_i)
			ecc_st <= nand_pkg::ECC_OK;
		else if (ce_i && rd_page_done_i && correction_enable_i)
		begin
			if (buffer_read_select_i)
				ecc_st <= rd_result_i;
			else if (rd_result_i[1])
				ecc_st <= ecc_st[1] ? nand_pkg::ECC_FAIL_MULTI : nand_pkg::ECC_FAIL;
			else if (!ecc_st[1] && rd_result_i != nand_pkg::ECC_OK)
				ecc_st <= nand_pkg::ECC_FIXED;
			if (rd_result_i[1])
				fail_page <= rd_page_i;
		end
	end

	assign busy_o = busy;
	assign write_latch_flag_o = write_latch_flag;
	assign correction_status_o = ecc_st;
	assign fail_page_o = fail_page;
endmodule : nand_dev
`default_nettype wire

// *** core/nand_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module nand_host (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic ce_i, // clock enable
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	nand_link_if.host link // serial link
);
	typedef enum logic {H_IDLE, H_SHIFT} hst_t;

	function automatic nand_pkg::frame_t plan(input logic [7:0] c, input logic [15:0] a);
		plan = '{tx: {c, 24'h0}, txn: nand_pkg::CNT_OP, rxn: 5'h0};
		if (c == nand_pkg::OP_ERASE)
			plan = '{tx: {c, 8'h0, a}, txn: nand_pkg::CNT_ERASE, rxn: 5'h0};
		else if (c == nand_pkg::OP_FAILPG)
			plan = '{tx: {c, 24'h0}, txn: nand_pkg::CNT_DUMMY, rxn: 5'h10};
		else if (c == nand_pkg::OP_RDSR_A || c == nand_pkg::OP_RDSR_B)
			plan = '{tx: {c, a[7:0], 16'h0}, txn: nand_pkg::CNT_DUMMY, rxn: 5'h08};
		else if (c == nand_pkg::OP_LOAD || c == nand_pkg::OP_RLOAD || c == nand_pkg::OP_QLOAD ||
			c == nand_pkg::OP_QRLOAD)
			plan = '{tx: {c, a, 8'h0}, txn: nand_pkg::CNT_COL, rxn: 5'h0};
	endfunction : plan
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	hst_t st;
	logic [7:0] op;
	logic [15:0] addr;
	logic [15:0] len;
	logic [15:0] left;
	logic [7:0] dat;
	logic dat_full;
	logic [31:0] tx;
	logic [5:0] txn;
	logic [4:0] rxn;
	logic rdpend;
	logic [15:0] rx;
	logic [15:0] result;
	logic quad;
	logic [1:0] div;
	logic sclk;
	logic cs_n;
	logic io1_s1;
	logic io1_s2;
	nand_pkg::frame_t fr;

	// ---------------------------------------------------------------
	// wishbone slave; a data write waits while the byte slot is full
	// ---------------------------------------------------------------
	wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic dat_wr = wb_we_i && (wb_adr_i == nand_pkg::WB_DATA);
	wire logic take = req && !(dat_wr && dat_full);
	wire logic wr = take && wb_we_i;
	wire logic start = wr && wb_adr_i == nand_pkg::WB_CMD && wb_sel_i[0] && st == H_IDLE;
	wire logic tick = (div == nand_pkg::SCLK_HALF_LAST);
	wire logic need_byte = (txn == 6'h0) && (left != 16'h0);
	wire logic all_done = (txn == 6'h0) && (left == 16'h0) && (rxn == 5'h0) && !rdpend;
	wire logic [5:0] step = quad ? 6'h4 : 6'h1;
	wire logic is_q = (op == nand_pkg::OP_QLOAD) || (op == nand_pkg::OP_QRLOAD);
	wire logic [31:0] rd_mux = (wb_adr_i == nand_pkg::WB_CMD) ? {24'h0, op} :
		(wb_adr_i == nand_pkg::WB_ADDR) ? {16'h0, addr} :
		(wb_adr_i == nand_pkg::WB_LEN) ? {16'h0, len} :
		(wb_adr_i == nand_pkg::WB_STAT) ? {15'h0, st == H_SHIFT, result} : 32'h0;

	assign fr = plan(wb_dat_i[7:0], addr);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			addr <= '0;
			len <= '0;
		end
		else if (ce_i)
		begin
			wb_ack_o <= take;
			wb_dat_o <= take ? rd_mux : 32'h0;
			if (wr && wb_adr_i == nand_pkg::WB_ADDR && st == H_IDLE)
				addr <= merge16(addr, wb_dat_i, wb_sel_i);
			if (wr && wb_adr_i == nand_pkg::WB_LEN && st == H_IDLE)
				len <= merge16(len, wb_dat_i, wb_sel_i);
		end
	end

	// ---------------------------------------------------------------
	// frame engine: bits change on the falling half, so the device
	// sees a stable line at every rising edge it samples
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			io1_s1 <= 1'b1;
			io1_s2 <= 1'b1;
		end
		else if (ce_i)
		begin
			io1_s1 <= link.io[1];
			io1_s2 <= io1_s1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st <= H_IDLE;
			op <= nand_pkg::OP_NONE;
			{tx, txn, rxn, rdpend, rx, result, left, dat, dat_full} <= '0;
			{quad, div, sclk} <= '0;
			cs_n <= 1'b1;
		end
		else if (ce_i)
		begin
			if (wr && dat_wr && wb_sel_i[0])
			begin
				dat <= wb_dat_i[7:0];
				dat_full <= 1'b1;
			end
			case (st)
				H_IDLE:
					if (start)
					begin
						op <= wb_dat_i[7:0];
						{tx, txn, rxn} <= {fr.tx, fr.txn, fr.rxn};
						left <= len;
						quad <= 1'b0;
						div <= '0;
						cs_n <= 1'b0;
						st <= H_SHIFT;
					end
				H_SHIFT:
				begin
					div <= tick ? 2'h0 : div + 2'h1;
					if (tick && !sclk && all_done)
					begin
						cs_n <= 1'b1;
						result <= rx;
						st <= H_IDLE;
					end
					else if (tick && !sclk && need_byte && dat_full)
					begin
						tx <= {dat, 24'h0};
						txn <= nand_pkg::CNT_OP;
						quad <= is_q;
						left <= left - 16'h1;
						dat_full <= 1'b0;
					end
					else if (tick && !sclk && !need_byte)
					begin
						sclk <= 1'b1;
						rdpend <= (txn == 6'h0) && (rxn != 5'h0);
					end
					else if (tick && sclk)
					begin
						sclk <= 1'b0;
						if (txn != 6'h0)
						begin
							tx <= tx << step;
							txn <= txn - step;
						end
						else if (rdpend)
						begin
							rx <= {rx[14:0], io1_s2};
							rxn <= rxn - 5'h1;
							rdpend <= 1'b0;
						end
					end
				end
				default:
					st <= H_IDLE;
			endcase
		end
	end

	assign link.cs_n = cs_n;
	assign link.sclk = sclk;
	assign link.h_io_o = quad ? tx[31:28] : {3'h0, tx[31]};
	assign link.h_io_oe = (st == H_SHIFT && txn != 6'h0) ? (quad ? 4'hf : 4'h1) : 4'h0;
endmodule : nand_host
`default_nettype wire

// *** core/nand_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface nand_link_if;
	logic cs_n;
	logic sclk;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe;
	logic d_do;
	logic d_do_oe;
	logic [3:0] io;
	// undriven lines read high, as with pull-ups
	assign io[0] = h_io_oe[0] ? h_io_o[0] : 1'b1;
	assign io[1] = h_io_oe[1] ? h_io_o[1] : (d_do_oe ? d_do : 1'b1);
	assign io[2] = h_io_oe[2] ? h_io_o[2] : 1'b1;
	assign io[3] = h_io_oe[3] ? h_io_o[3] : 1'b1;
	modport device (input cs_n, input sclk, input io, output d_do, output d_do_oe);
	modport host (output cs_n, output sclk, output h_io_o, output h_io_oe, input io);
endinterface : nand_link_if
`default_nettype wire

// *** core/nand_pkg.sv ***
package nand_pkg;
	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_NONE = 8'h00;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR_A = 8'h0f;
	localparam logic [7:0] OP_RDSR_B = 8'h05;
	localparam logic [7:0] OP_FAILPG = 8'ha9;
	localparam logic [7:0] OP_ERASE = 8'hd8;
	localparam logic [7:0] OP_LOAD = 8'h02;
	localparam logic [7:0] OP_RLOAD = 8'h84;
	localparam logic [7:0] OP_QLOAD = 8'h32;
	localparam logic [7:0] OP_QRLOAD = 8'h34;
	// ---------------------------------------------------------------
	// page buffer and frame layout
	// ---------------------------------------------------------------
	localparam int PAGE_BYTES = 2112;
	localparam logic [11:0] PAGE_END = 12'h840;
	localparam int MAIN_BYTES = 2048;
	localparam logic [11:0] PARITY_IDX = 12'h804;
	localparam logic [7:0] FILL_BYTE = 8'hff;
	localparam logic [5:0] CNT_OP = 6'h08;
	localparam logic [5:0] CNT_DUMMY = 6'h10;
	localparam logic [5:0] CNT_COL = 6'h18;
	localparam logic [5:0] CNT_ERASE = 6'h20;
	localparam logic [5:0] CNT_MAX = 6'h3f;
	localparam logic [5:0] PIN_IDLE = 6'h2f;
	localparam int BLK_LSB = 6;
	localparam logic [10:0] BLOCKS = 11'h400;
	localparam logic [2:0] LVL_ALL = 3'h7;
	// ---------------------------------------------------------------
	// status byte and correction codes
	// ---------------------------------------------------------------
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_ECC = 4;
	localparam logic [1:0] ECC_OK = 2'h0;
	localparam logic [1:0] ECC_FIXED = 2'h1;
	localparam logic [1:0] ECC_FAIL = 2'h2;
	localparam logic [1:0] ECC_FAIL_MULTI = 2'h3;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int ERASE_TIME_US = 2000;
	localparam int ERASE_CYCLES = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_PERIOD_NS = 160;
	localparam logic [1:0] SCLK_HALF_LAST = 2'((SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS - 1);
	// ---------------------------------------------------------------
	// host wishbone map
	// ---------------------------------------------------------------
	localparam logic [7:0] WB_CMD = 8'h00;
	localparam logic [7:0] WB_ADDR = 8'h04;
	localparam logic [7:0] WB_LEN = 8'h08;
	localparam logic [7:0] WB_DATA = 8'h0c;
	localparam logic [7:0] WB_STAT = 8'h10;
	localparam int STAT_BUSY_BIT = 16;
	typedef struct packed {
		logic [31:0] tx;
		logic [5:0] txn;
		logic [4:0] rxn;
	} frame_t;
endpackage : nand_pkg

// *** sim/nand_link_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module nand_link_checker (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic cs_n, // chip select
	input wire logic sclk, // link clock
	input wire logic [3:0] h_io_oe, // host enables
	input wire logic d_do_oe // device enable
);
	logic sq;
	logic [11:0] nr;
	// --------
	// rising link clock edges in the current frame
	// --------
	always_ff @(posedge clk_i)
	begin
		sq <= sclk;
		nr <= (rst_i || cs_n) ? 12'h000 : nr + 12'(sclk && !sq);
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("sclk not idle");
	a_sclk_high_half: assert property ($rose(sclk) |-> sclk [*4])
		else $error("short high");
	a_sclk_low_half: assert property ($fell(sclk) |-> !sclk [*4])
		else $error("short low");
	a_frame_has_op: assert property ($rose(cs_n) |-> nr >= 12'h008)
		else $error("frame without opcode");
	a_op_on_io0: assert property (!cs_n && sclk && nr < 12'h008 |-> h_io_oe[0])
		else $error("opcode not driven");
	a_dev_early: assert property (!cs_n && nr < 12'h010 |-> !d_do_oe)
		else $error("device drives early");
	a_dev_idle: assert property (cs_n [*6] |-> !d_do_oe)
		else $error("device drives idle");
	a_no_fight: assert property (!(d_do_oe && h_io_oe[1]))
		else $error("io1 contention");
	a_host_idle: assert property (cs_n [*2] |-> h_io_oe == 4'h0)
		else $error("host drives idle");
	cover property ($rose(cs_n) && nr == 12'h020);
	cover property ($rose(d_do_oe));
	cover property (!cs_n && h_io_oe == 4'hf);
endmodule : nand_link_checker
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
	typedef struct packed {logic [7:0] op; logic [15:0] col; logic [7:0] d;
		logic ecc; logic [11:0] idx; logic [7:0] exp;} row_t;
	localparam int EC = 600;
	// --------
	// loads: opcode, column, byte, ecc, index read back, byte there
	// --------
	row_t rows[10] = '{
		'{8'h02, 16'h0000, 8'ha5, 1'h1, 12'h000, 8'ha5},
		'{8'h02, 16'h0000, 8'ha5, 1'h1, 12'h804, 8'h5a},
		'{8'h84, 16'h0010, 8'h3c, 1'h0, 12'h000, 8'ha5},
		'{8'h02, 16'hf020, 8'h77, 1'h0, 12'h020, 8'h77},
		'{8'h02, 16'hf020, 8'h77, 1'h0, 12'h000, 8'hff},
		'{8'h32, 16'h0005, 8'hc3, 1'h0, 12'h005, 8'hc3},
		'{8'h34, 16'h0006, 8'h11, 1'h0, 12'h005, 8'hc3},
		'{8'h02, 16'h083f, 8'h9e, 1'h0, 12'h83f, 8'h9e},
		'{8'h84, 16'h0840, 8'h66, 1'h0, 12'h000, 8'hff},
		'{8'h02, 16'h0804, 8'h4b, 1'h0, 12'h804, 8'h4b}};
	logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, sq = 1'h0;
	logic ecc = 1'h1, bsel = 1'h0, wpe = 1'h0, tbot = 1'h0, rds = 1'h0, rdd = 1'h0;
	logic ack, busy, write_latch_flag, est, edn;
	logic [1:0] rres = 2'h0, cst;
	logic [2:0] lvl = 3'h0;
	logic [3:0] sel = 4'hf;
	logic [7:0] adr = 8'h00, bdat;
	logic [9:0] eblk;
	logic [11:0] idx = 12'h000;
	logic [15:0] rpg = 16'h0000, fpg;
	logic [31:0] wdat = 32'h0, rdat, wdo;
	int fails = 0, samples_checked = 0, starts = 0, dones = 0, bcnt = 0, rc = 0, n;
	nand_link_if i_nand_link_if();
	nand_host i_nand_host(.clk_i, .rst_i, .ce_i(1'h1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wdo),
		.wb_ack_o(ack), .link(i_nand_link_if.host));
	nand_dev #(.ERASE_CYCLES(EC)) i_nand_dev(.clk_i, .rst_i, .ce_i(1'h1),
		.link(i_nand_link_if.device), .correction_enable_i(ecc), .buffer_read_select_i(bsel),
		.protect_pin_enable_i(wpe), .protect_top_bottom_i(tbot), .protect_level_bit2_i(lvl[2]),
		.protect_level_bit1_i(lvl[1]), .protect_level_bit0_i(lvl[0]), .rd_start_i(rds),
		.rd_page_done_i(rdd), .rd_result_i(rres), .rd_page_i(rpg), .buf_idx_i(idx),
		.buf_data_o(bdat), .busy_o(busy), .write_latch_flag_o(write_latch_flag), .erase_start_o(est),
		.erase_block_o(eblk), .erase_done_o(edn), .correction_status_o(cst), .fail_page_o(fpg));
	nand_link_checker i_nand_link_checker(.clk_i, .rst_i, .cs_n(i_nand_link_if.cs_n),
		.sclk(i_nand_link_if.sclk), .h_io_oe(i_nand_link_if.h_io_oe),
		.d_do_oe(i_nand_link_if.d_do_oe));
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'h1)
			@(posedge clk_i);
		rdat = wdo;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask : wb
	// the tail wait lets the device's pin synchronisers see the frame end
	task run(input logic [7:0] op, input logic [15:0] a, input logic nb, input logic [7:0] d);
		wb(1'h1, 8'h04, {16'h0, a});
		wb(1'h1, 8'h08, {31'h0, nb});
		wb(1'h1, 8'h00, {24'h0, op});
		if (nb)
			wb(1'h1, 8'h0c, {24'h0, d});
		do
			wb(1'h0, 8'h10, 32'h0);
		while (rdat[16] !== 1'h0);
		repeat (12) @(posedge clk_i);
	endtask : run
	task pg(input logic [1:0] r, input logic [15:0] p);
		rdd <= 1'h1;
		rres <= r;
		rpg <= p;
		@(posedge clk_i);
		rdd <= 1'h0;
		@(posedge clk_i);
	endtask : pg
	task look(input logic [11:0] i);
		idx <= i;
		repeat (3) @(posedge clk_i);
	endtask : look
	task results;
		$display("compares %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	always @(posedge clk_i)
	begin
		sq <= i_nand_link_if.sclk;
		rc = rc + int'(i_nand_link_if.sclk && !sq);
		starts = starts + int'(est === 1'h1);
		dones = dones + int'(edn === 1'h1);
		bcnt = bcnt + int'(busy === 1'h1);
	end
	initial forever #10 clk_i = ~clk_i;
	initial
	begin
		repeat (40000) @(posedge clk_i);
		fails++;
		results();
	end
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		foreach (rows[i])
		begin
			ecc <= rows[i].ecc;
			run(8'h06, 16'h0, 1'h0, 8'h0);
			run(rows[i].op, rows[i].col, 1'h1, rows[i].d);
			look(rows[i].idx);
			chk("buffer", 16'(rows[i].exp), 16'(bdat));
		end
		lvl <= 3'h7;
		run(8'h06, 16'h0, 1'h0, 8'h0);
		chk("wel", 16'h1, 16'(write_latch_flag));
		run(8'hd8, 16'h0085, 1'h0, 8'h0);
		chk("starts", 16'h0, 16'(starts));
		lvl <= 3'h0;
		run(8'h04, 16'h0, 1'h0, 8'h0);
		run(8'hd8, 16'h0085, 1'h0, 8'h0);
		chk("starts", 16'h0, 16'(starts));
		run(8'h06, 16'h0, 1'h0, 8'h0);
		rc = 0;
		run(8'hd8, 16'h0085, 1'h0, 8'h0);
		chk("rises", 16'h20, 16'(rc));
		run(8'h0f, 16'h0, 1'h0, 8'h0);
		chk("status", 16'h3, 16'(rdat[1:0]));
		chk("block", 16'h2, 16'(eblk));
		n = 0;
		while (busy !== 1'h0 && n < 2000)
		begin
			@(posedge clk_i);
			n++;
		end
		repeat (2) @(posedge clk_i);
		chk("busy_len", 16'(EC), 16'(bcnt));
		chk("dones", 16'h1, 16'(dones));
		chk("wel", 16'h0, 16'(write_latch_flag));
		// status only updates with correction on; the clear gets a cycle of its own
		ecc <= 1'h1;
		rds <= 1'h1;
		@(posedge clk_i);
		rds <= 1'h0;
		pg(2'h2, 16'h0123);
		pg(2'h3, 16'h0456);
		pg(2'h1, 16'h0007);
		chk("ecc_st", 16'h3, 16'(cst));
		chk("fail_page", 16'h0456, fpg);
		run(8'ha9, 16'h0, 1'h0, 8'h0);
		chk("fail_pg", 16'h0456, rdat[15:0]);
		run(8'h0f, 16'h0, 1'h0, 8'h0);
		chk("st_ecc", 16'h3, 16'(rdat[5:4]));
		bsel <= 1'h1;
		pg(2'h1, 16'h0009);
		chk("ecc_st", 16'h1, 16'(cst));
		run(8'h02, 16'h0, 1'h1, 8'h12);
		wpe <= 1'h1;
		run(8'h06, 16'h0, 1'h0, 8'h0);
		run(8'h32, 16'h0, 1'h1, 8'h34);
		look(12'h000);
		chk("buf0", 16'hff, 16'(bdat));
		wb(1'h0, 8'h20, 32'h0);
		chk("unmapped", 16'h0, rdat[15:0]);
		look(12'h804);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		chk("buf_rst", 16'hff, 16'(bdat));
		chk("wel_rst", 16'h0, 16'(write_latch_flag));
		chk("cs_rst", 16'h1, 16'(i_nand_link_if.cs_n));
		results();
	end
endmodule : testbench
`default_nettype wire
